// >>> rtl/fbs_pkg.sv
// Purpose: constants for the flow-through burst memory control block
// Assumes: one clock at 25 MHz, synchronous active-high reset
// Notes: Functional notes list the behaviour kept by the control logic
package fbs_pkg;
   localparam int FBS_ADDR_W = 20;
   localparam int FBS_DATA_W = 18;
   localparam int FBS_LANE_W = 9;
   localparam int FBS_FIFO_DEPTH = 16;
   localparam logic [1:0] FBS_BURST_ZERO = 2'h0;
   localparam logic [1:0] FBS_BURST_ONE = 2'h1;
   localparam logic [1:0] FBS_LANE_NONE = 2'h0;
   localparam logic [1:0] FBS_LANE_ALL = 2'h3;
   // access state, gray coded along idle -> read -> write -> snooze
   typedef enum logic [1:0] {
      FBS_IDLE  = 2'b00,
      FBS_READ  = 2'b01,
      FBS_WRITE = 2'b11,
      FBS_SNOOZE = 2'b10
   } fbs_state_e;
endpackage

// >>> rtl/fbs_fifo.sv
// Purpose: small synchronous fifo for write data
// Assumes: single clock, synchronous active-high reset
// Notes: read data come from a register; full and empty are exact
`timescale 1ns/1ps
module fbs_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys_i, // system clock
   input wire logic sys_rst_i, // sync reset
   input wire logic in_valid_i, // write side valid
   output logic in_ready_o, // write side ready
   input wire logic [WIDTH-1:0] in_data_i, // write data
   output logic out_valid_o, // read side valid
   input wire logic out_ready_i, // read side ready
   output logic [WIDTH-1:0] out_data_o // read data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;
   logic mem_valid;

   // handshake terms
   assign in_ready_o = (count != (AW+1)'(DEPTH));
   assign push = in_valid_i && in_ready_o;
   assign mem_valid = (count != '0);
   assign pop = mem_valid && (!out_valid_o || out_ready_i);

   // storage
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= rd_ptr + AW'(1);
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // registered output stage
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         out_valid_o <= 1'b0;
         out_data_o <= '0;
      end else if (pop) begin
         out_valid_o <= 1'b1;
         out_data_o <= mem[rd_ptr];
      end else if (out_ready_i) begin
         out_valid_o <= 1'b0;
      end
   end
endmodule

// >>> rtl/fbs_ctrl.sv
// Purpose: control logic of a flow-through burst synchronous memory
// Assumes: pins sampled on clk_sys_i; array side drains write data from a fifo
// Notes: array storage sits outside; this block issues word address and lane strobes
`timescale 1ns/1ps
module fbs_ctrl
   import fbs_pkg::*;
#(
   parameter int ADDR_W = FBS_ADDR_W,
   parameter int DEPTH = FBS_FIFO_DEPTH
) (
   input wire logic clk_sys_i, // system clock
   input wire logic sys_rst_i, // sync reset
   input wire logic [ADDR_W-1:0] addr_i, // external address
   input wire logic master_select_n_i, // master chip select
   input wire logic select_hi_i, // active high select
   input wire logic select_lo_n_i, // active low select
   input wire logic proc_addr_strobe_n_i, // processor strobe
   input wire logic ctrl_addr_strobe_n_i, // controller strobe
   input wire logic burst_advance_n_i, // burst advance
   input wire logic global_write_enable_n_i, // global write
   input wire logic byte_gate_n_i, // byte gate
   input wire logic lane_a_write_n_i, // lane a write
   input wire logic lane_b_write_n_i, // lane b write
   input wire logic output_enable_n_i, // output enable
   input wire logic burst_order_select_i, // 1 interleaved, 0 linear
   input wire logic sleep_request_i, // snooze request
   input wire logic [FBS_DATA_W-1:0] dq_in_i, // data pins in
   output logic [FBS_DATA_W-1:0] dq_out_o, // data pins out
   output logic [1:0] dq_oe_n_o, // per lane enable, low drives
   input wire logic [FBS_DATA_W-1:0] rd_data_i, // array read data
   output logic [ADDR_W-1:0] mem_addr_o, // array word address
   output logic wr_valid_o, // array write valid
   input wire logic wr_ready_i, // array write ready
   output logic [FBS_DATA_W-1:0] wr_data_o, // array write data
   output logic [1:0] wr_lanes_o, // array lane mask
   output logic snooze_o, // snooze state
   output logic busy_o // write stalled by full fifo
);
   localparam int FW = FBS_DATA_W + 2 + ADDR_W;
   fbs_state_e state;
   logic [ADDR_W-1:0] base_addr;
   logic [1:0] start_bits;
   logic [1:0] step;
   logic selected_now;
   logic any_strobe;
   logic proc_start;
   logic ctrl_start;
   logic deselect;
   logic advance;
   logic [1:0] lanes;
   logic is_write;
   logic [1:0] next_step;
   logic [1:0] low_bits;
   logic [ADDR_W-1:0] cur_addr;
   logic load;
   logic stepping;
   logic [ADDR_W-1:0] next_base;
   logic [1:0] next_start;
   logic [1:0] next_count;
   logic [1:0] next_low;
   logic beat_write;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [FW-1:0] fifo_out;

   // -------------------------------------------------
   // strobe and select decode
   // -------------------------------------------------
   // select qualification on the sampling edge
   assign selected_now = !master_select_n_i && select_hi_i && !select_lo_n_i;
   assign any_strobe = !proc_addr_strobe_n_i || !ctrl_addr_strobe_n_i;
   // processor strobe blocked by inactive master select
   assign proc_start = !proc_addr_strobe_n_i && !master_select_n_i && selected_now;
   assign ctrl_start = !ctrl_addr_strobe_n_i && proc_addr_strobe_n_i
                       && selected_now;
   // controller strobe, or processor strobe with master select active, seen but selects not all active: go to standby
   assign deselect = ((!proc_addr_strobe_n_i && !master_select_n_i)
                      || !ctrl_addr_strobe_n_i) && !selected_now;
   assign advance = !burst_advance_n_i && proc_addr_strobe_n_i
                    && ctrl_addr_strobe_n_i;

   // -------------------------------------------------
   // write enable decode
   // -------------------------------------------------
   always_comb begin
      if (!global_write_enable_n_i) begin
         lanes = FBS_LANE_ALL;
      end else if (!byte_gate_n_i) begin
         lanes = {!lane_b_write_n_i, !lane_a_write_n_i};
      end else begin
         lanes = FBS_LANE_NONE;
      end
   end
   assign is_write = (lanes != FBS_LANE_NONE);

   // -------------------------------------------------
   // burst address generation
   // -------------------------------------------------
   assign next_step = step + FBS_BURST_ONE;
   // upper bits kept; only two low bits follow the burst order
   always_comb begin
      if (burst_order_select_i) begin
         low_bits = start_bits ^ step;
      end else begin
         low_bits = start_bits + step;
      end
   end
   assign cur_addr = {base_addr[ADDR_W-1:2], low_bits};

   // load and step qualifiers, nothing taken while asleep
   assign load = !sleep_request_i && any_strobe && (proc_start || ctrl_start);
   assign stepping = !sleep_request_i && advance && state != FBS_IDLE;

   // next burst address, so the array sees it in the cycle it is registered
   always_comb begin
      next_base = base_addr;
      next_start = start_bits;
      next_count = step;
      if (load) begin
         next_base = addr_i;
         next_start = addr_i[1:0];
         next_count = FBS_BURST_ZERO;
      end else if (stepping) begin
         next_count = next_step;
      end
      if (burst_order_select_i) begin
         next_low = next_start ^ next_count;
      end else begin
         next_low = next_start + next_count;
      end
   end

   // address register and step count
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         base_addr <= '0;
         start_bits <= FBS_BURST_ZERO;
         step <= FBS_BURST_ZERO;
      end else begin
         base_addr <= next_base;
         start_bits <= next_start;
         step <= next_count;
      end
   end

   // -------------------------------------------------
   // access state
   // -------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state <= FBS_IDLE;
      end else begin
         case (state)
            FBS_SNOOZE: begin
               if (!sleep_request_i) begin
                  state <= FBS_IDLE;
               end
            end
            default: begin
               if (sleep_request_i) begin
                  state <= FBS_SNOOZE;
               end else if (proc_start) begin
                  state <= FBS_READ;
               end else if (ctrl_start) begin
                  state <= is_write ? FBS_WRITE : FBS_READ;
               end else if (deselect) begin
                  state <= FBS_IDLE;
               end else if (state != FBS_IDLE && proc_addr_strobe_n_i
                            && ctrl_addr_strobe_n_i) begin
                  state <= is_write ? FBS_WRITE : FBS_READ;
               end
            end
         endcase
      end
   end

   // -------------------------------------------------
   // write path through fifo
   // -------------------------------------------------
   // a write beat: controller start with write, or continuing write edge
   assign beat_write = !sleep_request_i && is_write
                       && (ctrl_start || (state != FBS_IDLE && state != FBS_SNOOZE
                           && proc_addr_strobe_n_i && ctrl_addr_strobe_n_i));

   fbs_fifo #(
      .WIDTH(FW),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(beat_write),
      .in_ready_o(fifo_in_ready),
      .in_data_i({dq_in_i, lanes, ctrl_start ? addr_i : cur_addr}),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(wr_ready_i),
      .out_data_o(fifo_out)
   );
   assign wr_valid_o = fifo_out_valid;
   assign wr_data_o = fifo_out[FW-1 -: FBS_DATA_W];
   assign wr_lanes_o = fifo_out[ADDR_W +: 2];

   // stall flag when a write beat meets a full fifo
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= beat_write && !fifo_in_ready;
      end
   end

   // -------------------------------------------------
   // read path and pin drive
   // -------------------------------------------------
   // array address follows the registered burst address
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         mem_addr_o <= '0;
         snooze_o <= 1'b0;
      end else begin
         mem_addr_o <= {next_base[ADDR_W-1:2], next_low};
         snooze_o <= sleep_request_i;
      end
   end

   // array data registered onto the pins, presented one cycle after the access cycle
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         dq_out_o <= '0;
      end else begin
         dq_out_o <= rd_data_i;
      end
   end

   // pin enable: read state, output enable low, not asleep
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         dq_oe_n_o <= FBS_LANE_ALL;
      end else if (state == FBS_READ && !output_enable_n_i
                   && !sleep_request_i) begin
         dq_oe_n_o <= FBS_LANE_NONE;
      end else begin
         dq_oe_n_o <= FBS_LANE_ALL;
      end
   end
   // output enable, sleep and burst order are used as levels without edge qualification
endmodule

// >>> verification/fbs_ctrl_asserts.sv
// Purpose: port checks for the burst memory control block
// Assumes: one clock, sync active-high reset
// Notes: bound to fbs_ctrl below
`timescale 1ns/1ps
module fbs_ctrl_asserts #(
   parameter int ADDR_W = 20
) (
   input wire logic clk_sys_i, // clock
   input wire logic sys_rst_i, // reset
   input wire logic [ADDR_W-1:0] addr_i, // address
   input wire logic master_select_n_i, // master select
   input wire logic select_hi_i, // select high
   input wire logic select_lo_n_i, // select low
   input wire logic proc_addr_strobe_n_i, // proc strobe
   input wire logic ctrl_addr_strobe_n_i, // ctrl strobe
   input wire logic burst_advance_n_i, // advance
   input wire logic global_write_enable_n_i, // global write
   input wire logic output_enable_n_i, // output enable
   input wire logic sleep_request_i, // sleep
   input wire logic [1:0] dq_oe_n_o, // drive enable
   input wire logic [ADDR_W-1:0] mem_addr_o, // word address
   input wire logic wr_valid_o, // write valid
   input wire logic [1:0] wr_lanes_o, // lane mask
   input wire logic snooze_o, // snooze
   input wire logic busy_o // full stall
);
   default clocking dc @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);
   logic awake;
   logic cst;
   logic start;
   logic quiet;
   // start and strobe decode
   assign awake = !sleep_request_i && !snooze_o;
   assign cst = !ctrl_addr_strobe_n_i && proc_addr_strobe_n_i;
   assign quiet = proc_addr_strobe_n_i && ctrl_addr_strobe_n_i;
   assign start = awake && select_hi_i && !select_lo_n_i && !master_select_n_i
      && (cst || !proc_addr_strobe_n_i);
   chk_start_addr: assert property (start |=> mem_addr_o == $past(addr_i))
      else $error("address not taken on start");
   chk_addr_hold: assert property (quiet && burst_advance_n_i |=> $stable(mem_addr_o))
      else $error("address moved without advance");
   chk_upper_keep: assert property (quiet |=> $stable(mem_addr_o[ADDR_W-1:2]))
      else $error("upper address bits moved in burst");
   chk_proc_blocked: assert property (master_select_n_i && !proc_addr_strobe_n_i
      && ctrl_addr_strobe_n_i |=> $stable(mem_addr_o))
      else $error("proc strobe taken while master off");
   chk_snooze_enter: assert property (sleep_request_i |=> snooze_o)
      else $error("snooze not entered");
   chk_snooze_leave: assert property (!sleep_request_i |=> !snooze_o)
      else $error("snooze outlasted request");
   chk_snooze_hiz: assert property (snooze_o |-> dq_oe_n_o == 2'h3)
      else $error("pins driven in snooze");
   chk_oe_off: assert property (output_enable_n_i |=> dq_oe_n_o == 2'h3)
      else $error("pins driven with enable off");
   chk_gwe_lanes: assert property (start && cst && !global_write_enable_n_i && !wr_valid_o
      && !busy_o |-> ##[1:3] (wr_valid_o && wr_lanes_o == 2'h3))
      else $error("global write lost lanes");
   // main scenarios reached
   cover property (snooze_o);
   cover property (busy_o);
   cover property (wr_valid_o && wr_lanes_o == 2'h1);
endmodule
bind fbs_ctrl fbs_ctrl_asserts #(.ADDR_W(ADDR_W)) i_fbs_ctrl_asserts (.clk_sys_i, .sys_rst_i,
   .addr_i, .master_select_n_i, .select_hi_i, .select_lo_n_i, .proc_addr_strobe_n_i,
   .ctrl_addr_strobe_n_i, .burst_advance_n_i, .global_write_enable_n_i, .output_enable_n_i,
   .sleep_request_i, .dq_oe_n_o, .mem_addr_o, .wr_valid_o, .wr_lanes_o, .snooze_o, .busy_o);

// >>> verification/fbs_array_model.sv
// Purpose: storage array beside the control block
// Assumes: read word follows the address at once
// Notes: write side stalls only on request
`timescale 1ns/1ps
module fbs_array_model #(
   parameter int ADDR_W = 20
) (
   input wire logic [ADDR_W-1:0] mem_addr_i, // word address
   input wire logic stall_i, // hold off writes
   output logic [17:0] rd_data_o, // read word
   output logic wr_ready_o // write accepted
);
   // flow-through read word, no register stage
   assign rd_data_o = mem_addr_i[17:0] ^ 18'h2A5A5;
   // write acceptance
   assign wr_ready_o = !stall_i;
endmodule

// >>> verification/fbs_ctrl_bench.sv
// Purpose: self-checking bench for the burst memory control block
// Assumes: inputs driven on the falling edge
// Notes: row fields p,ms_n,shi,slo_n,gw_n,bw_n,la_n,lb_n,wr,lanes[2],drive
`timescale 1ns/1ps
module fbs_ctrl_bench;
   import fbs_pkg::*;
   localparam logic [11:0] ROWS [11] = '{12'h27E, 12'h29A, 12'h2AC, 12'h28E, 12'h2C1,
      12'h2B1, 12'hA01, 12'h670, 12'hEF0, 12'h070, 12'h3F0};
   logic clk, rst, ms_n, shi, slo_n, ps_n, cs_n, adv_n, gw_n, bw_n, la_n, lb_n;
   logic oe_n, burst_order_select, zz, stall, wv, wr, snz, busy, seen;
   logic [19:0] a, maddr, hold_a;
   logic [17:0] dqi, rd, dqo, wd, wdat;
   logic [1:0] dq_oe_n, wl, lanes, exp;
   logic [11:0] r;
   int errors, checks, n;
   fbs_ctrl i_fbs_ctrl (.clk_sys_i(clk), .sys_rst_i(rst), .addr_i(a),
      .master_select_n_i(ms_n), .select_hi_i(shi), .select_lo_n_i(slo_n),
      .proc_addr_strobe_n_i(ps_n), .ctrl_addr_strobe_n_i(cs_n), .burst_advance_n_i(adv_n),
      .global_write_enable_n_i(gw_n), .byte_gate_n_i(bw_n), .lane_a_write_n_i(la_n),
      .lane_b_write_n_i(lb_n), .output_enable_n_i(oe_n), .burst_order_select_i(burst_order_select),
      .sleep_request_i(zz), .dq_in_i(dqi), .dq_out_o(dqo), .dq_oe_n_o(dq_oe_n),
      .rd_data_i(rd), .mem_addr_o(maddr), .wr_valid_o(wv), .wr_ready_i(wr),
      .wr_data_o(wd), .wr_lanes_o(wl), .snooze_o(snz), .busy_o(busy));
   fbs_array_model i_fbs_array_model (.mem_addr_i(maddr), .stall_i(stall),
      .rd_data_o(rd), .wr_ready_o(wr));
   // clock
   always #20 clk = ~clk;
   task automatic chk(input logic [19:0] got, input logic [19:0] want);
      checks++;
      if (got !== want) begin
         errors++;
         $display("[ERR] %0t got %h want %h", $time, got, want);
      end
   endtask
   task automatic idle();
      {ps_n, cs_n, adv_n, gw_n, bw_n, la_n, lb_n} = 7'h7F;
   endtask
   task automatic strobe(input logic [19:0] ad);
      @(negedge clk);
      a = ad;
      cs_n = 1'b0;
      @(negedge clk);
      cs_n = 1'b1;
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog
   initial begin
      #(2000 * 40);
      errors++;
      give_verdict();
   end
   // main sequence
   initial begin
      errors = 0;
      checks = 0;
      clk = 1'b0;
      rst = 1'b1;
      a = 20'h0;
      dqi = 18'h1234;
      {zz, burst_order_select, stall, ms_n, shi, slo_n, oe_n} = 7'h29;
      idle();
      repeat (4) @(negedge clk);
      rst = 1'b0;
      chk({dq_oe_n, snz, busy, wv}, 5'h18);
      chk(maddr, 20'h0);
      $display("reset test done");
      for (int i = 0; i < 11; i++) begin
         r = ROWS[i];
         @(negedge clk);
         {ms_n, shi, slo_n, gw_n, bw_n, la_n, lb_n} = r[10:4];
         {ps_n, cs_n, oe_n} = {!r[11], r[11], r[3]};
         a = 20'h100 + 20'(i);
         @(negedge clk);
         idle();
         {ms_n, shi, slo_n} = 3'h2;
         {n, seen} = 0;
         repeat (4) begin
            @(negedge clk);
            if (wv && wr) begin
               n++;
               lanes = wl;
               wdat = wd;
            end
            if (dq_oe_n == 2'h0) seen = 1'b1;
         end
         chk(20'(n), 20'(r[3]));
         if (r[3]) chk(20'(lanes), 20'(r[2:1]));
         if (r[3]) chk(20'(wdat), 20'(dqi));
         if (r[0]) chk(20'(dqo), 20'(18'(20'h100 + 20'(i)) ^ 18'h2A5A5));
         chk(20'(seen), 20'(r[0]));
         @(negedge clk);
         {oe_n, shi, cs_n} = 3'h4;
         @(negedge clk);
         {shi, cs_n} = 2'h3;
      end
      $display("row test done");
      for (int o = 0; o < 2; o++) begin
         for (int s = 0; s < 4; s++) begin
            burst_order_select = 1'(o);
            strobe({18'h2C3A1, 2'(s)});
            for (int k = 0; k < 4; k++) begin
               exp = burst_order_select ? 2'(s) ^ 2'(k) : 2'(s + k);
               chk(maddr, {18'h2C3A1, exp});
               if (k == 1) begin
                  @(negedge clk);
                  chk(maddr, {18'h2C3A1, exp});
               end
               adv_n = 1'b0;
               @(negedge clk);
               adv_n = 1'b1;
            end
         end
      end
      $display("burst test done");
      hold_a = maddr;
      zz = 1'b1;
      oe_n = 1'b0;
      strobe(20'h0ABC4);
      chk({snz, dq_oe_n}, 3'h7);
      chk(maddr, hold_a);
      zz = 1'b0;
      @(negedge clk);
      chk(20'(snz), 20'h0);
      strobe(20'h0ABC4);
      chk(maddr, 20'h0ABC4);
      $display("snooze test done");
      {oe_n, stall, seen} = 3'h6;
      @(negedge clk);
      {a, cs_n, gw_n} = {20'h00040, 2'h0};
      repeat (22) begin
         @(negedge clk);
         {cs_n, adv_n} = 2'h2;
         if (busy) seen = 1'b1;
      end
      idle();
      stall = 1'b0;
      n = 0;
      repeat (40) begin
         @(negedge clk);
         if (wv) n++;
      end
      chk({seen, wv}, 2'h2);
      chk(20'(n), 20'(FBS_FIFO_DEPTH));
      $display("fifo test done");
      give_verdict();
   end
endmodule
